// *** include/iplr_pkg.sv ***
package iplr_pkg;

    localparam int IPLR_DATA_W = 16;
    localparam int IPLR_ADDR_W = 5;
    localparam int IPLR_NUM_REG = 5;
    localparam int IPLR_NUM_SRC = 30;
    localparam int IPLR_CODE_W = 2;
    localparam int IPLR_SRC_W = 5;

    localparam logic [4:0] IPLR_OFF_DEBUG = 5'h01;
    localparam logic [4:0] IPLR_OFF_FLASH_CLOCK_EXT = 5'h02;
    localparam logic [4:0] IPLR_OFF_PORTS_DEF_CANBUS = 5'h03;
    localparam logic [4:0] IPLR_OFF_SERIAL_PORTS_ABC = 5'h04;
    localparam logic [4:0] IPLR_OFF_DECODER_ASYNC = 5'h05;

    localparam logic [15:0] IPLR_RESET_VALUE = 16'h0000;
    localparam logic [15:0] IPLR_READ_UNMAPPED = 16'h0000;

    localparam logic [15:0] IPLR_MASK_DEBUG = 16'h003F;
    localparam logic [15:0] IPLR_MASK_FLASH_CLOCK_EXT = 16'hFFCF;
    localparam logic [15:0] IPLR_MASK_PORTS_DEF_CANBUS = 16'hFFFC;
    localparam logic [15:0] IPLR_MASK_SERIAL_PORTS_ABC = 16'hFC3F;
    localparam logic [15:0] IPLR_MASK_DECODER_ASYNC = 16'hFF3F;

    localparam logic [4:0] IPLR_REG_OFF [0:4] = '{IPLR_OFF_DEBUG, IPLR_OFF_FLASH_CLOCK_EXT,
        IPLR_OFF_PORTS_DEF_CANBUS, IPLR_OFF_SERIAL_PORTS_ABC, IPLR_OFF_DECODER_ASYNC};
    localparam logic [15:0] IPLR_REG_MASK [0:4] = '{IPLR_MASK_DEBUG, IPLR_MASK_FLASH_CLOCK_EXT,
        IPLR_MASK_PORTS_DEF_CANBUS, IPLR_MASK_SERIAL_PORTS_ABC, IPLR_MASK_DECODER_ASYNC};

    // register slot 0 holds the debug-unit sources
    localparam int IPLR_DEBUG_SLOT = 0;

    // source table: slot and field low bit, by source index
    // 0-2 debug rx/tx/trace; 3-9 flash be/cc/err, lock, lvi, ext b, ext a
    // 10-16 port d/e/f, can msg/wkup/err/boff; 17-22 ser0 rx, ser1 tx/rx, port a/b/c
    // 23-29 dec1 index/home, async1 rx/rerr/tidle/tx, ser0 tx
    // register slot for every source
    localparam int IPLR_SRC_REG [0:29] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2,
        3, 3, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4, 4};
    localparam int IPLR_SRC_LSB [0:29] = '{4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2,
        14, 12, 10, 4, 2, 0, 14, 12, 10, 8, 4, 2, 0};

    localparam logic [1:0] IPLR_CODE_OFF = 2'h0;
    localparam logic [1:0] IPLR_LEVEL_STEP = 2'h1;

    typedef struct packed {
        logic [4:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } iplr_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [4:0] source;
    } iplr_grant_t;

endpackage

// *** core/iplr_prio_reg.sv ***
`timescale 1ns/100ps
module iplr_prio_reg #(
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    output logic [15:0] q
);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            q <= iplr_pkg::IPLR_RESET_VALUE;
        // write lands on its own edge
        end else if (wr_en) begin
            q <= wdata & WMASK;
        end
    end

endmodule

// *** core/iplr_level_decode.sv ***
`timescale 1ns/100ps
module iplr_level_decode (
    input wire logic [1:0] code,
    input wire logic debug_class,
    output logic enabled,
    output logic [1:0] level
);

    always_comb begin
        enabled = (code != iplr_pkg::IPLR_CODE_OFF);
        if (debug_class) begin
            level = code;
        end else if (enabled) begin
            level = code - iplr_pkg::IPLR_LEVEL_STEP;
        end else begin
            level = 2'h0;
        end
    end

endmodule

// *** core/iplr_top.sv ***
`timescale 1ns/100ps
module iplr_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire iplr_pkg::iplr_bus_req_t bus_req,
    output logic [15:0] rd_data_q,
    input wire logic [29:0] src_pending,
    output logic [29:0] fwd_req_q,
    output logic [59:0] fwd_level_q,
    output iplr_pkg::iplr_grant_t core_grant_q,
    output logic wake_req_q
);

    localparam int NREG = iplr_pkg::IPLR_NUM_REG;
    localparam int NSRC = iplr_pkg::IPLR_NUM_SRC;

    logic [15:0] reg_q [0:NREG-1];
    logic [NREG-1:0] hit;
    logic [15:0] rd_mux;
    logic [NSRC-1:0] src_enabled;
    logic [1:0] src_level [0:NSRC-1];
    logic [NSRC-1:0] fwd_req_d;
    logic [59:0] fwd_level_d;
    iplr_pkg::iplr_grant_t grant_d;

    genvar r;
    generate
        for (r = 0; r < NREG; r++) begin : g_reg
            assign hit[r] = (bus_req.addr == iplr_pkg::IPLR_REG_OFF[r]);
            iplr_prio_reg #(
                .WMASK(iplr_pkg::IPLR_REG_MASK[r])
            ) u_reg (
                .sys_clk(sys_clk),
                .reset(reset),
                .wr_en(bus_req.wr & hit[r]),
                .wdata(bus_req.wdata),
                .q(reg_q[r])
            );
        end
    endgenerate

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = iplr_pkg::IPLR_READ_UNMAPPED;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_mux = reg_q[i];
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= 16'h0000;
        end else if (bus_req.rd) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= 16'h0000;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : g_src
            iplr_level_decode u_dec (
                .code(reg_q[iplr_pkg::IPLR_SRC_REG[s]][iplr_pkg::IPLR_SRC_LSB[s] +: 2]),
                .debug_class(iplr_pkg::IPLR_SRC_REG[s] == iplr_pkg::IPLR_DEBUG_SLOT),
                .enabled(src_enabled[s]),
                .level(src_level[s])
            );
            assign fwd_req_d[s] = src_pending[s] & src_enabled[s];
            assign fwd_level_d[2*s +: 2] = src_enabled[s] ? src_level[s] : 2'h0;
        end
    endgenerate

    // highest level wins, lowest index breaks ties
    always_comb begin
        grant_d = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (fwd_req_d[i] && (!grant_d.valid || src_level[i] > grant_d.level)) begin
                grant_d.valid = 1'b1;
                grant_d.level = src_level[i];
                grant_d.source = 5'(i);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fwd_req_q <= '0;
            fwd_level_q <= '0;
        end else begin
            fwd_req_q <= fwd_req_d;
            fwd_level_q <= fwd_level_d;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            core_grant_q <= '0;
        end else begin
            core_grant_q <= grant_d;
        end
    end

    // wake request from any forwarded source
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wake_req_q <= 1'b0;
        end else begin
            wake_req_q <= |fwd_req_d;
        end
    end

endmodule

// *** verif/iplr_props.sv ***
`timescale 1ns/100ps
module iplr_props (
    input wire logic sys_clk,
    input wire logic reset,
    input wire iplr_pkg::iplr_bus_req_t bus_req,
    input wire logic [15:0] rd_data_q,
    input wire logic [29:0] src_pending,
    input wire logic [29:0] fwd_req_q,
    input wire logic [59:0] fwd_level_q,
    input wire iplr_pkg::iplr_grant_t core_grant_q,
    input wire logic wake_req_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data_q == 16'h0000) else $error("idle read");
    AST_UNMAP: assert property (bus_req.rd && bus_req.addr == 5'h00 |=> rd_data_q == 16'h0000) else $error("unmap");
    AST_RSV_DBG: assert property (bus_req.rd && bus_req.addr == 5'h01 |=> rd_data_q[15:6] == 10'h000) else $error("rsv1");
    AST_RSV_FLASH: assert property (bus_req.rd && bus_req.addr == 5'h02 |=> rd_data_q[5:4] == 2'h0) else $error("rsv2");
    AST_RSV_PORTS: assert property (bus_req.rd && bus_req.addr == 5'h03 |=> rd_data_q[1:0] == 2'h0) else $error("rsv3");
    AST_FWD_CAUSE: assert property (1'b1 |=> (fwd_req_q & ~$past(src_pending)) == 30'h00000000) else $error("fwd");
    AST_WAKE: assert property (wake_req_q == |fwd_req_q) else $error("wake");
    AST_GRANT: assert property (core_grant_q.valid == |fwd_req_q) else $error("grant");
    AST_GRANT_LVL: assert property (core_grant_q.valid |-> fwd_req_q[core_grant_q.source]
        && core_grant_q.level == fwd_level_q[2*core_grant_q.source +: 2]) else $error("grant lvl");
    AST_DBG_LVL: assert property (fwd_req_q[0] |-> fwd_level_q[1:0] != 2'h0) else $error("dbg lvl");
endmodule
bind iplr_top iplr_props u_props (.sys_clk, .reset, .bus_req, .rd_data_q, .src_pending, .fwd_req_q,
    .fwd_level_q, .core_grant_q, .wake_req_q);

// *** verif/iplr_src_model.sv ***
`timescale 1ns/100ps
module iplr_src_model (
    input wire logic sys_clk,
    input wire logic [29:0] raise,
    output logic [29:0] src_pending
);
    // peripherals hold requests as levels
    always_ff @(posedge sys_clk) begin
        src_pending <= raise;
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    iplr_pkg::iplr_bus_req_t bus_req = '0;
    logic [29:0] raise = 30'h00000000;
    logic [29:0] src_pending;
    logic [15:0] rd_data_q;
    logic [29:0] fwd_req_q;
    logic [59:0] fwd_level_q;
    iplr_pkg::iplr_grant_t core_grant_q;
    logic wake_req_q;
    int n_mismatch = 0;
    int n_checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    iplr_src_model u_src (.sys_clk, .raise, .src_pending);
    iplr_top dut (.sys_clk, .reset, .bus_req, .rd_data_q, .src_pending, .fwd_req_q, .fwd_level_q,
        .core_grant_q, .wake_req_q);
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk_val(rd_data_q, exp);
    endtask
    task automatic t_reset_vals();
        for (int i = 0; i < 5; i++) begin
            rd(iplr_pkg::IPLR_REG_OFF[i], 16'h0000);
        end
    endtask
    task automatic t_masks();
        wr(5'h06, 16'hFFFF);
        rd(5'h06, 16'h0000);
        rd(5'h00, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(iplr_pkg::IPLR_REG_OFF[i], 16'hFFFF);
            rd(iplr_pkg::IPLR_REG_OFF[i], iplr_pkg::IPLR_REG_MASK[i]);
        end
    endtask
    task automatic t_levels();
        logic [1:0] lvl;
        logic on;
        for (int s = 0; s < 30; s++) begin
            for (int c = 0; c < 4; c++) begin
                on = (c != 0);
                lvl = (s < 3 || !on) ? 2'(c) : 2'(c - 1);
                wr(iplr_pkg::IPLR_REG_OFF[iplr_pkg::IPLR_SRC_REG[s]], 16'(c) << iplr_pkg::IPLR_SRC_LSB[s]);
                raise <= 30'h00000001 << s;
                repeat (3) @(posedge sys_clk);
                #1 chk_val({4'h0, fwd_req_q[s], fwd_level_q[2*s +: 2], wake_req_q, core_grant_q},
                    {4'h0, on, lvl, on, on, lvl, on ? 5'(s) : 5'h00});
                raise <= 30'h00000000;
            end
        end
    endtask
    task automatic t_arbitrate();
        wr(iplr_pkg::IPLR_OFF_DEBUG, 16'h0010);
        wr(iplr_pkg::IPLR_OFF_FLASH_CLOCK_EXT, 16'hC002);
        raise <= 30'h00000209;
        repeat (3) @(posedge sys_clk);
        // higher level wins
        #1 chk_val({8'h00, core_grant_q}, {8'h00, 1'b1, 2'h2, 5'h03});
        raise <= 30'h00000201;
        repeat (3) @(posedge sys_clk);
        // equal levels, lowest index wins
        #1 chk_val({8'h00, core_grant_q}, {8'h00, 1'b1, 2'h1, 5'h00});
        raise <= 30'h00000000;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_vals();
        t_masks();
        // reset in mid-run clears all
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_vals();
        t_levels();
        t_arbitrate();
        wrap_up();
    end
endmodule
